// ==== scb_regs.vh ====
// Constants for the stream combiner
`ifndef SCB_REGS_VH
`define SCB_REGS_VH

// Port count limits
`define SCB_MIN_PORTS      2
`define SCB_MAX_PORTS      16

// Default configuration
`define SCB_DEF_PORTS      3
`define SCB_DEF_DATA_W     8
`define SCB_DEF_ID_W       1
`define SCB_DEF_DEST_W     1
`define SCB_DEF_USER_W     1
`define SCB_DEF_PRIMARY    0

// Data bits per byte; one strobe and one keep bit per byte
`define SCB_BITS_PER_BYTE  8

// Reset values of the outbound stage
`define SCB_RST_VALID      1'h0
`define SCB_RST_LAST       1'h0
`define SCB_RST_ERR        1'h0

`endif

// ==== scb_side_cmp.v ====
// Sideband comparator for one inbound port against the primary port
`timescale 1ns/1ps
module scb_side_cmp #(
    parameter ID_W     = 1,
    parameter DEST_W   = 1,
    parameter HAS_LAST = 1,
    parameter HAS_ID   = 1,
    parameter HAS_DEST = 1
) (
    // Port under test
    input  wire              last_in,
    input  wire [ID_W-1:0]   id_in,
    input  wire [DEST_W-1:0] dest_in,
    // Primary port
    input  wire              ref_last_in,
    input  wire [ID_W-1:0]   ref_id_in,
    input  wire [DEST_W-1:0] ref_dest_in,
    // Result
    output wire              mismatch_out
);
    wire last_diff;
    wire id_diff;
    wire dest_diff;

    // Absent signals never mismatch
    assign last_diff = (HAS_LAST != 0) && (last_in != ref_last_in);
    assign id_diff   = (HAS_ID != 0)   && (id_in != ref_id_in);
    assign dest_diff = (HAS_DEST != 0) && (dest_in != ref_dest_in);

    assign mismatch_out = last_diff | id_diff | dest_diff;
endmodule // scb_side_cmp

// ==== scb_combiner.v ====
// Stream combiner: several narrow inbound streams into one wide outbound stream
// Contract
// - Two to sixteen inbound streams, one outbound.
// - Payload, strobes, keeps, user concatenated in index order.
// - Last, id, dest copied from primary input.
// - Outbound valid only when every input valid.
// - Flag disagreeing last, id or dest.
// - Strobe and keep width is data/8.
// - Each signal optional; widths parameterised. Valid and ready are always present here.
// - Low port enable stalls the combined transfer; low outbound enable holds state.
`timescale 1ns/1ps
`include "scb_regs.vh"
module scb_combiner #(
    parameter NUM_IN    = `SCB_DEF_PORTS,
    parameter DATA_W    = `SCB_DEF_DATA_W,
    parameter ID_W      = `SCB_DEF_ID_W,
    parameter DEST_W    = `SCB_DEF_DEST_W,
    parameter USER_W    = `SCB_DEF_USER_W,
    parameter PRIMARY   = `SCB_DEF_PRIMARY,
    parameter HAS_DATA  = 1,
    parameter HAS_STRB  = 1,
    parameter HAS_KEEP  = 1,
    parameter HAS_LAST  = 1,
    parameter HAS_ID    = 1,
    parameter HAS_DEST  = 1,
    parameter HAS_USER  = 1,
    parameter HAS_CE    = 1
) (
    // Clock and reset
    input  wire                          core_clk_in,
    input  wire                          sys_rst_in,
    // Per-port clock enables, bit NUM_IN is the outbound port
    input  wire [NUM_IN:0]               port_clock_enable_in,
    // Inbound streams, port i in slice i
    input  wire [NUM_IN-1:0]             s_tvalid_in,
    output wire [NUM_IN-1:0]             s_tready_out,
    input  wire [NUM_IN*DATA_W-1:0]      s_tdata_in,
    input  wire [NUM_IN*DATA_W/8-1:0]    s_tstrb_in,
    input  wire [NUM_IN*DATA_W/8-1:0]    s_tkeep_in,
    input  wire [NUM_IN-1:0]             s_tlast_in,
    input  wire [NUM_IN*ID_W-1:0]        s_tid_in,
    input  wire [NUM_IN*DEST_W-1:0]      s_tdest_in,
    input  wire [NUM_IN*USER_W-1:0]      s_tuser_in,
    // Outbound stream
    output reg                           m_tvalid_out,
    input  wire                          m_tready_in,
    output reg  [NUM_IN*DATA_W-1:0]      m_tdata_out,
    output reg  [NUM_IN*DATA_W/8-1:0]    m_tstrb_out,
    output reg  [NUM_IN*DATA_W/8-1:0]    m_tkeep_out,
    output reg                           m_tlast_out,
    output reg  [ID_W-1:0]               m_tid_out,
    output reg  [DEST_W-1:0]             m_tdest_out,
    output reg  [NUM_IN*USER_W-1:0]      m_tuser_out,
    // Sideband disagreement
    output reg                           err_out,
    output reg  [NUM_IN-1:0]             err_port_out
);
    localparam BYTES_W = DATA_W / `SCB_BITS_PER_BYTE;
    localparam TOT_D   = NUM_IN * DATA_W;
    localparam TOT_B   = NUM_IN * BYTES_W;
    localparam TOT_U   = NUM_IN * USER_W;

    // Configuration limits; an illegal setting never completes a transfer
    localparam PORTS_OK = (NUM_IN >= `SCB_MIN_PORTS) && (NUM_IN <= `SCB_MAX_PORTS);
    localparam PRIM_OK  = (PRIMARY >= 0) && (PRIMARY < NUM_IN);
    localparam BYTE_OK  = (DATA_W % `SCB_BITS_PER_BYTE) == 0;
    localparam CFG_OK   = PORTS_OK && PRIM_OK && BYTE_OK;
    // Primary index kept inside the port range for the part-selects
    localparam PRIM_IDX = PRIM_OK ? PRIMARY : 0;

    wire              all_valid;
    wire              ce_in_all;
    wire              ce_out;
    wire              out_free;
    wire              accept;
    wire              prim_last;
    wire [ID_W-1:0]   prim_id;
    wire [DEST_W-1:0] prim_dest;
    wire [NUM_IN-1:0] port_mismatch;
    wire              any_mismatch;

    // Beat as it would be offered, absent fields filled in
    wire [TOT_D-1:0]  fmt_data;
    wire [TOT_B-1:0]  fmt_strb;
    wire [TOT_B-1:0]  fmt_keep;
    wire [TOT_U-1:0]  fmt_user;
    wire              fmt_last;
    wire [ID_W-1:0]   fmt_id;
    wire [DEST_W-1:0] fmt_dest;

    // Next values of the outbound registers
    reg               next_valid;
    reg [TOT_D-1:0]   next_data;
    reg [TOT_B-1:0]   next_strb;
    reg [TOT_B-1:0]   next_keep;
    reg [TOT_U-1:0]   next_user;
    reg               next_last;
    reg [ID_W-1:0]    next_id;
    reg [DEST_W-1:0]  next_dest;
    reg               next_err;
    reg [NUM_IN-1:0]  next_err_port;

    // Enables forced high when per-port enables are not configured
    assign ce_in_all = (HAS_CE == 0) ? 1'b1 : &port_clock_enable_in[NUM_IN-1:0];
    assign ce_out    = (HAS_CE == 0) ? 1'b1 : port_clock_enable_in[NUM_IN];

    assign all_valid = &s_tvalid_in;

    // Outbound register may load when empty or being drained
    assign out_free = !m_tvalid_out || m_tready_in;

    // One combined handshake for every port in the same cycle
    assign accept = (CFG_OK != 0) && !sys_rst_in && all_valid && m_tready_in
                    && ce_in_all && ce_out;

    assign s_tready_out = {NUM_IN{accept}};

    // Primary port sidebands
    assign prim_last = s_tlast_in[PRIM_IDX];
    assign prim_id   = s_tid_in[PRIM_IDX*ID_W +: ID_W];
    assign prim_dest = s_tdest_in[PRIM_IDX*DEST_W +: DEST_W];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_cmp
            scb_side_cmp #(
                .ID_W     (ID_W),
                .DEST_W   (DEST_W),
                .HAS_LAST (HAS_LAST),
                .HAS_ID   (HAS_ID),
                .HAS_DEST (HAS_DEST)
            ) u_cmp (
                .last_in      (s_tlast_in[gi]),
                .id_in        (s_tid_in[gi*ID_W +: ID_W]),
                .dest_in      (s_tdest_in[gi*DEST_W +: DEST_W]),
                .ref_last_in  (prim_last),
                .ref_id_in    (prim_id),
                .ref_dest_in  (prim_dest),
                .mismatch_out (port_mismatch[gi])
            );
        end
    endgenerate

    assign any_mismatch = |port_mismatch;

    // Absent payload fields read as zero, absent keep as all ones, absent strobe as the keep value
    assign fmt_data = (HAS_DATA != 0) ? s_tdata_in : {TOT_D{1'b0}};
    assign fmt_strb = (HAS_STRB != 0) ? s_tstrb_in : fmt_keep;
    assign fmt_keep = (HAS_KEEP != 0) ? s_tkeep_in : {TOT_B{1'b1}};
    assign fmt_user = (HAS_USER != 0) ? s_tuser_in : {TOT_U{1'b0}};
    assign fmt_last = (HAS_LAST != 0) ? prim_last : 1'b1;
    assign fmt_id   = (HAS_ID != 0) ? prim_id : {ID_W{1'b0}};
    assign fmt_dest = (HAS_DEST != 0) ? prim_dest : {DEST_W{1'b0}};

    // Load or drain the beat; everything holds while the outbound port is disabled
    always @* begin
        next_valid = m_tvalid_out;
        next_data  = m_tdata_out;
        next_strb  = m_tstrb_out;
        next_keep  = m_tkeep_out;
        next_user  = m_tuser_out;
        next_last  = m_tlast_out;
        next_id    = m_tid_out;
        next_dest  = m_tdest_out;
        if (ce_out && out_free) begin
            next_valid = accept;
            if (accept) begin
                next_data = fmt_data;
                next_strb = fmt_strb;
                next_keep = fmt_keep;
                next_user = fmt_user;
                next_last = fmt_last;
                next_id   = fmt_id;
                next_dest = fmt_dest;
            end
        end
    end

    // Mismatch pulse, held while the outbound port is disabled
    always @* begin
        next_err      = err_out;
        next_err_port = err_port_out;
        if (ce_out) begin
            next_err      = accept && any_mismatch;
            next_err_port = accept ? port_mismatch : {NUM_IN{1'b0}};
        end
    end

    // Outbound register stage
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            m_tvalid_out <= `SCB_RST_VALID;
            m_tdata_out  <= {TOT_D{1'b0}};
            m_tstrb_out  <= {TOT_B{1'b0}};
            m_tkeep_out  <= {TOT_B{1'b0}};
            m_tlast_out  <= `SCB_RST_LAST;
            m_tid_out    <= {ID_W{1'b0}};
            m_tdest_out  <= {DEST_W{1'b0}};
            m_tuser_out  <= {TOT_U{1'b0}};
        end else begin
            m_tvalid_out <= next_valid;
            m_tdata_out  <= next_data;
            m_tstrb_out  <= next_strb;
            m_tkeep_out  <= next_keep;
            m_tlast_out  <= next_last;
            m_tid_out    <= next_id;
            m_tdest_out  <= next_dest;
            m_tuser_out  <= next_user;
        end
    end

    // One pulse per combined transfer that disagrees
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            err_out      <= `SCB_RST_ERR;
            err_port_out <= {NUM_IN{1'b0}};
        end else begin
            err_out      <= next_err;
            err_port_out <= next_err_port;
        end
    end
endmodule // scb_combiner

// ==== scb_combiner_asserts.sv ====
// Port assertions for the stream combiner
`timescale 1ns/1ps
module scb_combiner_asserts #(
    parameter NUM_IN  = 3,
    parameter DATA_W  = 8,
    parameter PRIMARY = 0
) (
    // Clock and reset
    input wire                     core_clk_in,
    input wire                     sys_rst_in,
    // Inbound side
    input wire [NUM_IN:0]          port_clock_enable_in,
    input wire [NUM_IN-1:0]        s_tvalid_in,
    input wire [NUM_IN-1:0]        s_tready_out,
    input wire [NUM_IN*DATA_W-1:0] s_tdata_in,
    input wire [NUM_IN-1:0]        s_tlast_in,
    // Outbound side
    input wire                     m_tvalid_out,
    input wire                     m_tready_in,
    input wire [NUM_IN*DATA_W-1:0] m_tdata_out,
    input wire                     m_tlast_out,
    input wire                     err_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire take = s_tready_out[0];
    chk_rdy_cause: assert property (
        s_tready_out == {NUM_IN{&s_tvalid_in && m_tready_in && &port_clock_enable_in}})
        else $error("inbound ready wrong");
    chk_valid_after: assert property (take |=> m_tvalid_out)
        else $error("beat not offered");
    chk_valid_cause: assert property ($rose(m_tvalid_out) |-> $past(take))
        else $error("valid without take");
    chk_data_cat: assert property (take |=> m_tdata_out == $past(s_tdata_in))
        else $error("data not concatenated");
    chk_last_prim: assert property (take |=> m_tlast_out == $past(s_tlast_in[PRIMARY]))
        else $error("last not from primary");
    chk_err_flag: assert property (
        take && s_tlast_in != {NUM_IN{s_tlast_in[PRIMARY]}} |=> err_out)
        else $error("mismatch not flagged");
    chk_beat_hold: assert property (
        m_tvalid_out && !(m_tready_in && port_clock_enable_in[NUM_IN])
        |=> m_tvalid_out && $stable(m_tdata_out)) else $error("beat not held");
    chk_rst_quiet: assert property (disable iff (1'b0)
        sys_rst_in |-> s_tready_out == 0 ##1 !m_tvalid_out) else $error("busy in reset");
endmodule // scb_combiner_asserts
bind scb_combiner scb_combiner_asserts #(.NUM_IN(NUM_IN), .DATA_W(DATA_W), .PRIMARY(PRIMARY)) u_chk (
    .core_clk_in, .sys_rst_in, .port_clock_enable_in, .s_tvalid_in, .s_tready_out,
    .s_tdata_in, .s_tlast_in, .m_tvalid_out, .m_tready_in, .m_tdata_out, .m_tlast_out,
    .err_out);

// ==== scb_sink_model.sv ====
// Downstream sink model, prompt or stalling
`timescale 1ns/1ps
module scb_sink_model (
    // Clock and reset
    input  wire core_clk_in,
    input  wire sys_rst_in,
    // Mode and handshake
    input  wire slow_in,
    output reg  ready_out = 1'b0
);
    reg [7:0] seed = 8'h5a;
    always @(posedge core_clk_in) begin
        seed      <= {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        ready_out <= !sys_rst_in && (!slow_in || seed[0]);
    end
endmodule // scb_sink_model

// ==== scb_combiner_tb.sv ====
// Self-checking bench for the stream combiner
`timescale 1ns/1ps
module scb_combiner_tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         slow = 1'b0;
    reg  [3:0]  en = 4'h0;
    reg  [2:0]  vld = 3'h0, strb = 3'h0, keep = 3'h0, last = 3'h0, id = 3'h0, dst = 3'h0;
    reg  [2:0]  usr = 3'h0, mm;
    reg         tk = 1'b0, xv = 1'b0;
    reg  [23:0] dat = 24'h0;
    reg  [15:0] r = 16'h001b;
    reg  [3:0]  ee = 4'h0;
    reg  [35:0] q[$];
    wire [35:0] got;
    wire [2:0]  rdy, ep;
    wire        mv, mr, err;
    integer     error_cnt = 0, n_checks = 0, cyc = 0, i;
    always #25 clk = ~clk;
    scb_combiner u_scb_combiner (.core_clk_in(clk), .sys_rst_in(rst), .port_clock_enable_in(en),
        .s_tvalid_in(vld), .s_tready_out(rdy), .s_tdata_in(dat), .s_tstrb_in(strb),
        .s_tkeep_in(keep), .s_tlast_in(last), .s_tid_in(id), .s_tdest_in(dst), .s_tuser_in(usr),
        .m_tvalid_out(mv), .m_tready_in(mr), .m_tdata_out(got[35:12]), .m_tstrb_out(got[11:9]),
        .m_tkeep_out(got[8:6]), .m_tuser_out(got[5:3]), .m_tlast_out(got[2]),
        .m_tid_out(got[1]), .m_tdest_out(got[0]), .err_out(err), .err_port_out(ep));
    scb_sink_model u_scb_sink_model (.core_clk_in(clk), .sys_rst_in(rst), .slow_in(slow),
        .ready_out(mr));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task check(input [35:0] seen, input [35:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Reference model and random sources
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end else begin
            if (!rst) begin
                tk = &vld & mr & &en;
                check({rdy, err, ep, mv}, {{3{tk}}, ee, xv});
                if (xv && mr && en[3]) check(got, q.size() ? q.pop_front() : 36'hx);
                if (tk) q.push_back({dat, strb, keep, usr, last[0], id[0], dst[0]});
                for (i = 0; i < 3; i = i + 1)
                    mm[i] = |({last[i], id[i], dst[i]} ^ {last[0], id[0], dst[0]});
                if (en[3]) ee = tk ? {|mm, mm} : 4'h0;
                if (en[3] && (mr || !xv)) xv = tk;
            end
            for (i = 0; i < 3; i = i + 1) begin
                r = lfsr(r);
                if (!vld[i] || rdy[0]) begin
                    vld[i] <= r[15] & !rst;
                    dat[i*8 +: 8] <= r[7:0];
                    {strb[i], keep[i], usr[i]} <= r[13:11];
                    {last[i], id[i], dst[i]} <= r[14] ? 3'h0 : r[10:8];
                end
            end
            r = lfsr(r);
            en <= ~(r[3:0] & r[7:4]);
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (1500) @(posedge clk);
        slow <= 1'b1;
        repeat (1500) @(posedge clk);
        summarize;
    end
endmodule // scb_combiner_tb
